/* verilog/dctm_core.sv */
`timescale 1ns/10ps
`default_nettype none
module dctm_core
  import dctm_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = DEF_SLAVE_ADDR,
  parameter bit VARIANT_B = 1'b0,
  parameter int unsigned CONV_LEN = CONV_CYCLES,
  parameter int unsigned RATE_GAP = RATE_GAP_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [10:0] local_code,
  input wire logic [10:0] remote_code,
  input wire logic diode_open,
  input wire logic diode_short,
  output logic alert_n_out,
  output logic alert_oe,
  output logic overtemp_shutdown_n_out,
  output logic overtemp_shutdown_n_oe
);
  // Pin synchronisers
  logic [1:0] scl_sync_ff, sda_sync_ff;
  logic scl_prev_ff, sda_prev_ff;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], scl_in};
      sda_sync_ff <= {sda_sync_ff[0], sda_in};
      scl_prev_ff <= scl_sync_ff[1];
      sda_prev_ff <= sda_sync_ff[1];
    end
  end
  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
  assign scl_s = scl_sync_ff[1];
  assign sda_s = sda_sync_ff[1];
  assign scl_rise = scl_s && !scl_prev_ff;
  assign scl_fall = !scl_s && scl_prev_ff;
  assign start_det = scl_s && scl_prev_ff && sda_prev_ff && !sda_s;
  assign stop_det = scl_s && scl_prev_ff && !sda_prev_ff && sda_s;
  // Register state
  logic [7:0] ptr_ff, cfg_ff, rate_ff;
  logic [7:0] lim_hi_ff [2], lim_lo_ff [2], lim_ovt_ff [2], temp_int_ff [2];
  logic [2:0] temp_frac_ff [2];
  logic [6:0] flag_ff;
  logic open_ff, alert_ff, shutdown_ff;
  dctm_conv_e cv_st_ff;
  logic [31:0] cv_cnt_ff;
  // Serial slave state
  dctm_smb_e sm_st_ff;
  logic [7:0] sh_ff, wr_data_ff, tx_src_ff;
  logic [3:0] bit_cnt_ff;
  logic drive_ff, ara_ff, oneshot_p_ff, wr_p_ff, rd_done_p_ff;
  logic conv_done, stby_set, busy;
  assign busy = (cv_st_ff == CV_BUSY);
  // Abort wins over a completion in the same cycle
  assign conv_done = busy && !stby_set && (cv_cnt_ff == CONV_LEN - 1);
  assign stby_set = wr_p_ff && (ptr_ff == REG_CFG_WR) && wr_data_ff[CFG_RUN_N_BIT] && !cfg_ff[CFG_RUN_N_BIT];
  // Newly sampled results, remote forced to fault code on a bad diode
  logic diode_fault;
  logic [7:0] new_int [2];
  logic [2:0] new_frac [2];
  assign diode_fault = diode_open || diode_short;
  assign new_int[CH_LOC] = local_code[10:3];
  assign new_frac[CH_LOC] = local_code[2:0];
  assign new_int[CH_REM] = diode_fault ? FAULT_CODE : remote_code[10:3];
  assign new_frac[CH_REM] = diode_fault ? 3'h0 : remote_code[2:0];
  // Per-channel comparisons on the new results
  logic [1:0] cmp_hi, cmp_lo, cmp_ovt;
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      assign cmp_hi[ch] = new_int[ch] >= lim_hi_ff[ch];
      assign cmp_lo[ch] = new_int[ch] < lim_lo_ff[ch];
      assign cmp_ovt[ch] = new_int[ch] >= lim_ovt_ff[ch];
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          temp_int_ff[ch] <= 8'h00;
          temp_frac_ff[ch] <= 3'h0;
        end else if (conv_done) begin
          temp_int_ff[ch] <= new_int[ch];
          temp_frac_ff[ch] <= new_frac[ch];
        end
      end
    end
  endgenerate
  // Live conditions, held from the last completed sequence
  logic [6:0] cond_ff, new_cond;
  logic open_alerts;
  assign open_alerts = VARIANT_B && diode_open;
  assign new_cond = {cmp_hi[CH_LOC], cmp_lo[CH_LOC], cmp_hi[CH_REM], cmp_lo[CH_REM],
                     diode_open, cmp_ovt[CH_REM], cmp_ovt[CH_LOC]};
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cond_ff <= 7'h00;
      open_ff <= 1'b0;
    end else if (conv_done) begin
      cond_ff <= new_cond;
      open_ff <= open_alerts;
    end
  end
  // Conversion sequencer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cv_st_ff <= CV_IDLE;
      cv_cnt_ff <= 32'h0;
    end else begin
      case (cv_st_ff)
        CV_IDLE: begin
          cv_cnt_ff <= 32'h0;
          if (oneshot_p_ff || !cfg_ff[CFG_RUN_N_BIT]) begin
            cv_st_ff <= CV_BUSY;
          end
        end
        CV_BUSY: begin
          if (stby_set) begin
            cv_st_ff <= CV_IDLE;
            cv_cnt_ff <= 32'h0;
          end else if (conv_done) begin
            cv_st_ff <= cfg_ff[CFG_RUN_N_BIT] ? CV_IDLE : CV_WAIT;
            cv_cnt_ff <= 32'h0;
          end else begin
            cv_cnt_ff <= cv_cnt_ff + 32'h1;
          end
        end
        CV_WAIT: begin
          if (cfg_ff[CFG_RUN_N_BIT]) begin
            cv_st_ff <= CV_IDLE;
            cv_cnt_ff <= 32'h0;
          end else if (oneshot_p_ff || cv_cnt_ff == RATE_GAP - 1) begin
            cv_st_ff <= CV_BUSY;
            cv_cnt_ff <= 32'h0;
          end else begin
            cv_cnt_ff <= cv_cnt_ff + 32'h1;
          end
        end
        default: begin
          cv_st_ff <= CV_IDLE;
          cv_cnt_ff <= 32'h0;
        end
      endcase
    end
  end
  // Sticky status flags, set wins over clear
  logic status_clr, ara_clr;
  assign status_clr = rd_done_p_ff && !ara_ff && (tx_src_ff == REG_STATUS);
  assign ara_clr = rd_done_p_ff && ara_ff;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flag_ff <= 7'h00;
    end else if (conv_done) begin
      flag_ff <= flag_ff | new_cond;
    end else if (status_clr) begin
      flag_ff <= flag_ff & cond_ff;
    end
  end
  // Alert latch and overtemp level
  logic alert_cond, alert_new;
  assign alert_cond = (|cond_ff[6:3]) || open_ff;
  assign alert_new = (|new_cond[6:3]) || open_alerts;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      alert_ff <= 1'b0;
    end else if (conv_done && alert_new && !cfg_ff[CFG_MASK_BIT]) begin
      alert_ff <= 1'b1;
    end else if ((status_clr || ara_clr) && !alert_cond) begin
      alert_ff <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shutdown_ff <= 1'b0;
    end else if (conv_done) begin
      shutdown_ff <= |cmp_ovt;
    end
  end
  // Writable registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= RST_CFG;
      rate_ff <= RST_RATE;
      lim_hi_ff[CH_LOC] <= RST_LHI;
      lim_hi_ff[CH_REM] <= VARIANT_B ? RST_RHI_B : RST_RHI_A;
      lim_lo_ff[CH_LOC] <= RST_LOW;
      lim_lo_ff[CH_REM] <= RST_LOW;
      lim_ovt_ff[CH_LOC] <= RST_OVT_LOC;
      lim_ovt_ff[CH_REM] <= VARIANT_B ? RST_OVT_REM_B : RST_OVT_REM_A;
    end else if (wr_p_ff) begin
      case (ptr_ff)
        REG_CFG_WR: cfg_ff <= wr_data_ff;
        REG_RATE_WR: rate_ff <= wr_data_ff;
        REG_LHI_WR: lim_hi_ff[CH_LOC] <= wr_data_ff;
        REG_LLO_WR: lim_lo_ff[CH_LOC] <= wr_data_ff;
        REG_RHI_WR: lim_hi_ff[CH_REM] <= wr_data_ff;
        REG_RLO_WR: lim_lo_ff[CH_REM] <= wr_data_ff;
        REG_OVT_REM: lim_ovt_ff[CH_REM] <= wr_data_ff;
        REG_OVT_LOC: lim_ovt_ff[CH_LOC] <= wr_data_ff;
        default: cfg_ff <= cfg_ff;
      endcase
    end
  end
  // Read data for the pointed register
  logic [7:0] rd_data;
  always_comb begin
    case (ptr_ff)
      REG_LOC_INT: rd_data = temp_int_ff[CH_LOC];
      REG_REM_INT: rd_data = temp_int_ff[CH_REM];
      REG_STATUS: rd_data = {busy, flag_ff};
      REG_CFG_RD: rd_data = cfg_ff;
      REG_RATE_RD: rd_data = rate_ff;
      REG_LHI_RD: rd_data = lim_hi_ff[CH_LOC];
      REG_LLO_RD: rd_data = lim_lo_ff[CH_LOC];
      REG_RHI_RD: rd_data = lim_hi_ff[CH_REM];
      REG_RLO_RD: rd_data = lim_lo_ff[CH_REM];
      REG_REM_FRAC: rd_data = {temp_frac_ff[CH_REM], 5'h00};
      REG_LOC_FRAC: rd_data = {temp_frac_ff[CH_LOC], 5'h00};
      REG_OVT_REM: rd_data = lim_ovt_ff[CH_REM];
      REG_OVT_LOC: rd_data = lim_ovt_ff[CH_LOC];
      default: rd_data = UNMAPPED_RD;
    endcase
  end
  // Serial slave; served in every mode, standby included
  logic [7:0] tx_byte;
  logic byte_end;
  assign tx_byte = ara_ff ? {SLAVE_ADDR, 1'b0} : rd_data;
  assign byte_end = scl_fall && (bit_cnt_ff == BITS_PER_BYTE);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sm_st_ff <= SM_IDLE;
      sh_ff <= 8'h00;
      bit_cnt_ff <= 4'h0;
      drive_ff <= 1'b0;
      ara_ff <= 1'b0;
      ptr_ff <= RST_PTR;
      oneshot_p_ff <= 1'b0;
      wr_p_ff <= 1'b0;
      wr_data_ff <= 8'h00;
      rd_done_p_ff <= 1'b0;
      tx_src_ff <= 8'h00;
    end else begin
      oneshot_p_ff <= 1'b0;
      wr_p_ff <= 1'b0;
      rd_done_p_ff <= 1'b0;
      if (start_det) begin
        sm_st_ff <= SM_ADDR;
        bit_cnt_ff <= 4'h0;
        drive_ff <= 1'b0;
        ara_ff <= 1'b0;
      end else if (stop_det) begin
        sm_st_ff <= SM_IDLE;
        drive_ff <= 1'b0;
      end else begin
        case (sm_st_ff)
          SM_ADDR, SM_CMD, SM_WDATA: begin
            if (scl_rise) begin
              sh_ff <= {sh_ff[6:0], sda_s};
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end else if (byte_end) begin
              bit_cnt_ff <= 4'h0;
              if (sm_st_ff == SM_ADDR) begin
                if (sh_ff[7:1] == SLAVE_ADDR) begin
                  drive_ff <= 1'b1;
                  sm_st_ff <= SM_AACK;
                end else if (sh_ff[7:1] == ALERT_RESP_ADDR && sh_ff[0] && alert_ff) begin
                  drive_ff <= 1'b1;
                  ara_ff <= 1'b1;
                  sm_st_ff <= SM_AACK;
                end else begin
                  sm_st_ff <= SM_IGN;
                end
              end else if (sm_st_ff == SM_CMD) begin
                drive_ff <= 1'b1;
                sm_st_ff <= SM_CACK;
                if (sh_ff == CMD_ONESHOT) begin
                  oneshot_p_ff <= 1'b1;
                end else begin
                  ptr_ff <= sh_ff;
                end
              end else begin
                drive_ff <= 1'b1;
                wr_p_ff <= 1'b1;
                wr_data_ff <= sh_ff;
                sm_st_ff <= SM_WACK;
              end
            end
          end
          SM_AACK: begin
            if (scl_fall) begin
              if (sh_ff[0]) begin
                sh_ff <= tx_byte;
                tx_src_ff <= ptr_ff;
                drive_ff <= !tx_byte[7];
                sm_st_ff <= SM_TX;
              end else begin
                drive_ff <= 1'b0;
                sm_st_ff <= SM_CMD;
              end
            end
          end
          SM_CACK: begin
            if (scl_fall) begin
              drive_ff <= 1'b0;
              sm_st_ff <= SM_WDATA;
            end
          end
          SM_WACK: begin
            if (scl_fall) begin
              drive_ff <= 1'b0;
              sm_st_ff <= SM_IGN;
            end
          end
          SM_TX: begin
            if (scl_rise) begin
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end else if (byte_end) begin
              drive_ff <= 1'b0;
              bit_cnt_ff <= 4'h0;
              sm_st_ff <= SM_TACK;
            end else if (scl_fall) begin
              sh_ff <= {sh_ff[6:0], 1'b0};
              drive_ff <= !sh_ff[6];
            end
          end
          SM_TACK: begin
            if (scl_rise) begin
              rd_done_p_ff <= 1'b1;
              sm_st_ff <= SM_IGN;
            end
          end
          SM_IDLE, SM_IGN: begin
            drive_ff <= 1'b0;
          end
          default: begin
            sm_st_ff <= SM_IDLE;
            drive_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = drive_ff;
  assign alert_n_out = 1'b0;
  assign alert_oe = alert_ff;
  assign overtemp_shutdown_n_out = 1'b0;
  assign overtemp_shutdown_n_oe = shutdown_ff;
  // Checks
  sequence s_busy_run;
    (cv_st_ff == CV_BUSY) && !stby_set && !conv_done;
  endsequence
  sequence s_abort_req;
    (cv_st_ff == CV_BUSY) && stby_set;
  endsequence
  a_busy_ends_done: assert property (@(posedge clk_sys) disable iff (!rst_n)
    conv_done |=> !busy || $past(oneshot_p_ff))
    else $error("busy still set after completion");
  a_results_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_busy_run |=> $stable(temp_int_ff[CH_LOC]) && $stable(temp_int_ff[CH_REM]))
    else $error("result changed mid conversion");
  a_standby_stays: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cv_st_ff == CV_IDLE && cfg_ff[CFG_RUN_N_BIT] && !oneshot_p_ff) |=> cv_st_ff == CV_IDLE)
    else $error("conversion started in standby");
  a_oneshot_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (oneshot_p_ff && cv_st_ff != CV_BUSY) |=> cv_st_ff == CV_BUSY)
    else $error("one-shot did not start a sequence");
  a_abort_keeps: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_abort_req |=> (cv_st_ff == CV_IDLE) && $stable(temp_int_ff[CH_REM]) && $stable(temp_frac_ff[CH_REM]))
    else $error("aborted conversion updated results");
  a_same_update: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (conv_done && !diode_fault) |=> {temp_int_ff[CH_LOC], temp_frac_ff[CH_LOC]} == $past(local_code)
      && {temp_int_ff[CH_REM], temp_frac_ff[CH_REM]} == $past(remote_code))
    else $error("main and extended not updated together");
  a_fault_code: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (conv_done && diode_fault) |=> temp_int_ff[CH_REM] == FAULT_CODE)
    else $error("fault code not loaded");
  a_alert_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (conv_done && cmp_hi[CH_LOC] && !cfg_ff[CFG_MASK_BIT]) |=> alert_ff [*2])
    else $error("alert missing on high limit");
  a_alert_latched: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (alert_ff && !status_clr && !ara_clr) |=> alert_ff)
    else $error("alert dropped without clear");
  a_shutdown_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
    conv_done |=> shutdown_ff == (|$past(cmp_ovt)))
    else $error("overtemp output wrong");
endmodule : dctm_core
`default_nettype wire

/* verilog/dctm_pkg.sv */
package dctm_pkg;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned CONV_TIME_MS = 125;
  localparam int unsigned CONV_CYCLES = CONV_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned RATE_GAP_MS = 125;
  localparam int unsigned RATE_GAP_CYCLES = RATE_GAP_MS * 1000000 / CLK_PERIOD_NS;
  // Slave address value is arbitrary
  localparam logic [6:0] DEF_SLAVE_ADDR = 7'h4D;
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;
  localparam logic [7:0] CMD_ONESHOT = 8'h0F;
  localparam logic [7:0] REG_LOC_INT = 8'h00;
  localparam logic [7:0] REG_REM_INT = 8'h01;
  localparam logic [7:0] REG_STATUS = 8'h02;
  localparam logic [7:0] REG_CFG_RD = 8'h03;
  localparam logic [7:0] REG_RATE_RD = 8'h04;
  localparam logic [7:0] REG_LHI_RD = 8'h05;
  localparam logic [7:0] REG_LLO_RD = 8'h06;
  localparam logic [7:0] REG_RHI_RD = 8'h07;
  localparam logic [7:0] REG_RLO_RD = 8'h08;
  localparam logic [7:0] REG_CFG_WR = 8'h09;
  localparam logic [7:0] REG_RATE_WR = 8'h0A;
  localparam logic [7:0] REG_LHI_WR = 8'h0B;
  localparam logic [7:0] REG_LLO_WR = 8'h0C;
  localparam logic [7:0] REG_RHI_WR = 8'h0D;
  localparam logic [7:0] REG_RLO_WR = 8'h0E;
  localparam logic [7:0] REG_REM_FRAC = 8'h10;
  localparam logic [7:0] REG_LOC_FRAC = 8'h11;
  localparam logic [7:0] REG_OVT_REM = 8'h19;
  localparam logic [7:0] REG_OVT_LOC = 8'h20;
  localparam logic [7:0] RST_PTR = 8'h00;
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [7:0] RST_RATE = 8'h07;
  localparam logic [7:0] RST_LHI = 8'h55;
  localparam logic [7:0] RST_RHI_A = 8'h5F;
  localparam logic [7:0] RST_RHI_B = 8'h55;
  localparam logic [7:0] RST_LOW = 8'h00;
  localparam logic [7:0] RST_OVT_LOC = 8'h55;
  localparam logic [7:0] RST_OVT_REM_A = 8'h7D;
  localparam logic [7:0] RST_OVT_REM_B = 8'h55;
  localparam logic [7:0] FAULT_CODE = 8'hFF;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;
  localparam int unsigned CFG_MASK_BIT = 7;
  localparam int unsigned CFG_RUN_N_BIT = 6;
  localparam int unsigned ST_BUSY_BIT = 7;
  localparam int unsigned ST_OPEN_BIT = 2;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int unsigned CH_LOC = 0;
  localparam int unsigned CH_REM = 1;
  typedef enum logic [1:0] {CV_IDLE = 2'b00, CV_BUSY = 2'b01, CV_WAIT = 2'b11} dctm_conv_e;
  typedef enum logic [3:0] {
    SM_IDLE = 4'b0000, SM_ADDR = 4'b0001, SM_AACK = 4'b0011, SM_CMD = 4'b0010,
    SM_CACK = 4'b0110, SM_WDATA = 4'b0111, SM_WACK = 4'b0101, SM_TX = 4'b0100,
    SM_TACK = 4'b1100, SM_IGN = 4'b1101
  } dctm_smb_e;
endpackage : dctm_pkg

/* bench/dctm_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module dctm_host_model
  import dctm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic qtr();
    repeat (2) @(posedge clk_sys);
  endtask : qtr
  // Extra quarter lets the slave drop its ack first
  task automatic start();
    qtr();
    sda_low <= 1'b0;
    qtr();
    scl <= 1'b1;
    qtr();
    sda_low <= 1'b1;
    qtr();
    scl <= 1'b0;
    qtr();
  endtask : start
  task automatic stop();
    sda_low <= 1'b1;
    qtr();
    scl <= 1'b1;
    qtr();
    sda_low <= 1'b0;
    qtr();
  endtask : stop
  task automatic bit_io(input logic b, output logic r);
    sda_low <= ~b;
    qtr();
    scl <= 1'b1;
    qtr();
    r = sda_line;
    qtr();
    scl <= 1'b0;
    qtr();
  endtask : bit_io
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask : put_byte
  task automatic get_byte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(1'b1, r);
  endtask : get_byte
  task automatic write_byte(input logic [7:0] cmd, input logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start();
    put_byte({DEF_SLAVE_ADDR, 1'b0}, a0);
    put_byte(cmd, a1);
    put_byte(d, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask : write_byte
  task automatic read_byte(input logic [7:0] cmd, output logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start();
    put_byte({DEF_SLAVE_ADDR, 1'b0}, a0);
    put_byte(cmd, a1);
    start();
    put_byte({DEF_SLAVE_ADDR, 1'b1}, a2);
    get_byte(d);
    stop();
    ok = a0 & a1 & a2;
  endtask : read_byte
  task automatic send_cmd(input logic [7:0] cmd, output logic ok);
    logic a0, a1;
    start();
    put_byte({DEF_SLAVE_ADDR, 1'b0}, a0);
    put_byte(cmd, a1);
    stop();
    ok = a0 & a1;
  endtask : send_cmd
  task automatic recv_byte(input logic [6:0] adr, output logic [7:0] d, output logic ok);
    start();
    put_byte({adr, 1'b1}, ok);
    get_byte(d);
    stop();
  endtask : recv_byte
endmodule : dctm_host_model
`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import dctm_pkg::*;
;
  logic clk_sys, rst_n, diode_open, diode_short, sda_in, ok;
  logic [10:0] local_code, remote_code;
  logic [7:0] d;
  wire logic scl, sda_low, sda_out, sda_oe, alert_n_out, alert_oe, ovt_out, ovt_oe;
  int err_count, total_checks;
  localparam logic [7:0] LIM_CMD [6] = '{REG_LHI_RD, REG_LLO_RD, REG_RHI_RD, REG_RLO_RD, REG_OVT_LOC, REG_OVT_REM};
  localparam logic [7:0] LIM_EXP [6] = '{8'h55, 8'h00, 8'h5F, 8'h00, 8'h55, 8'h7D};
  // Open-drain wire with pull-up
  assign sda_in = ~(sda_low | sda_oe);
  dctm_core #(.CONV_LEN(2000), .RATE_GAP(1000)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .local_code(local_code), .remote_code(remote_code),
    .diode_open(diode_open), .diode_short(diode_short), .alert_n_out(alert_n_out), .alert_oe(alert_oe),
    .overtemp_shutdown_n_out(ovt_out), .overtemp_shutdown_n_oe(ovt_oe));
  dctm_host_model host (.clk_sys(clk_sys), .sda_line(sda_in), .scl(scl), .sda_low(sda_low));
  always #12.5 clk_sys = ~clk_sys;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rd_chk(input logic [7:0] cmd, input logic [7:0] exp);
    host.read_byte(cmd, d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d, exp);
  endtask : rd_chk
  task automatic wr(input logic [7:0] cmd, input logic [7:0] v);
    host.write_byte(cmd, v, ok);
    chk({7'h00, ok}, 8'h01);
  endtask : wr
  task automatic complete_run();
    if (err_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (80000) @(posedge clk_sys);
    err_count++;
    $display("Error at %0t: run hung", $time);
    complete_run();
  end
  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    diode_open = 1'b0;
    diode_short = 1'b0;
    local_code = {8'h19, 3'b010};
    remote_code = {8'h2A, 3'b101};
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    host.recv_byte(DEF_SLAVE_ADDR, d, ok);
    chk(d, 8'h00);
    foreach (LIM_CMD[i]) begin
      rd_chk(LIM_CMD[i], LIM_EXP[i]);
    end
    repeat (400) @(posedge clk_sys);
    rd_chk(REG_LOC_INT, 8'h19);
    rd_chk(REG_LOC_FRAC, 8'h40);
    rd_chk(REG_REM_FRAC, 8'hA0);
    chk({6'h00, alert_oe, ovt_oe}, 8'h00);
    chk({5'h00, sda_out, alert_n_out, ovt_out}, 8'h00);
    wr(REG_CFG_WR, 8'h40);
    local_code <= {8'h60, 3'b011};
    remote_code <= {8'h20, 3'b100};
    repeat (4000) @(posedge clk_sys);
    rd_chk(REG_LOC_INT, 8'h19);
    rd_chk(REG_CFG_RD, 8'h40);
    host.send_cmd(CMD_ONESHOT, ok);
    chk({7'h00, ok}, 8'h01);
    rd_chk(REG_STATUS, 8'h80);
    chk(d & 8'h80, 8'h80);
    rd_chk(REG_LOC_INT, 8'h19);
    repeat (2200) @(posedge clk_sys);
    rd_chk(REG_LOC_INT, 8'h60);
    rd_chk(REG_LOC_FRAC, 8'h60);
    rd_chk(REG_REM_FRAC, 8'h80);
    rd_chk(REG_REM_INT, 8'h20);
    host.recv_byte(DEF_SLAVE_ADDR, d, ok);
    chk(d, 8'h20);
    host.read_byte(REG_STATUS, d, ok);
    chk(d & 8'h80, 8'h00);
    chk({6'h00, alert_oe, ovt_oe}, 8'h03);
    host.recv_byte(ALERT_RESP_ADDR, d, ok);
    chk({d[7:1], ok}, {DEF_SLAVE_ADDR, 1'b1});
    host.recv_byte(7'h4E, d, ok);
    chk({7'h00, ok}, 8'h00);
    wr(REG_RHI_WR, 8'h33);
    rd_chk(REG_RHI_RD, 8'h33);
    local_code <= {8'h70, 3'b000};
    wr(REG_CFG_WR, 8'h00);
    host.send_cmd(CMD_ONESHOT, ok);
    wr(REG_CFG_WR, 8'h40);
    repeat (3000) @(posedge clk_sys);
    rd_chk(REG_LOC_INT, 8'h60);
    diode_open <= 1'b1;
    wr(REG_LLO_WR, 8'h75);
    host.send_cmd(CMD_ONESHOT, ok);
    repeat (2200) @(posedge clk_sys);
    rd_chk(REG_REM_INT, 8'hFF);
    host.read_byte(REG_STATUS, d, ok);
    chk(d & 8'h24, 8'h24);
    diode_open <= 1'b0;
    local_code <= {8'h19, 3'h0};
    wr(REG_LLO_WR, 8'h00);
    host.send_cmd(CMD_ONESHOT, ok);
    repeat (2200) @(posedge clk_sys);
    host.read_byte(REG_STATUS, d, ok);
    chk({6'h00, alert_oe, ovt_oe}, 8'h00);
    rd_chk(REG_STATUS, 8'h00);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
